// *** rtl/ssp_defs.svh ***
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_WORD_W        32
`define SSP_NUM_REGS      14
`define SSP_LAST_REG      4'hd
// register 0
`define SSP_INT_LSB       4
`define SSP_PRESCALER_BIT 20
`define SSP_AUTOCAL_BIT   21
// register 1
`define SSP_MAIN_FRACTION_NUMERATOR_LSB     4
// registers 2 and 13: low and high halves of 28-bit values
`define SSP_AUX_MODULUS_LSB      4
`define SSP_AUX_FRACTION_NUMERATOR_LSB     18
// register 4
`define SSP_CP_LSB        10
`define SSP_DIV_DBUF_BIT  14
`define SSP_RDIV_LSB      15
`define SSP_HALVE_BIT     25
`define SSP_DOUBLER_BIT   26
`define SSP_MON_LSB       27
`define SSP_POL_BIT       7
// register 6
`define SSP_PWR_LSB       1
`define SSP_RFA_EN_BIT    6
`define SSP_RFB_EN_BIT    10
`define SSP_MUTE_BIT      11
`define SSP_ODIV_LSB      21
`define SSP_FB_SRC_BIT    24
// monitor select codes
`define SSP_MON_DLOCK     3'h1
`define SSP_MON_ALOCK     3'h2
`define SSP_MON_RFFB      3'h3
`define SSP_MON_REF       3'h4
// host register offsets and timing
`define SSP_ADDR_TXDATA   8'h00
`define SSP_ADDR_STATUS   8'h04
`define SSP_ADDR_HALFDIV  8'h08
`define SSP_HALFDIV_RST   8'h02
`define SSP_LE_HOLD_CYC   8'h04

`endif

// *** rtl/ssp_pkg.sv ***
package ssp_pkg;
    typedef logic [31:0] ssp_word_t;
    typedef enum logic [2:0]
    {
        SSP_H_IDLE  = 3'b001,
        SSP_H_SHIFT = 3'b010,
        SSP_H_LOAD  = 3'b100
    } ssp_host_st_t;
    typedef enum logic [1:0]
    {
        SSP_C_IDLE = 2'b01,
        SSP_C_RUN  = 2'b10
    } ssp_cal_st_t;
endpackage

// *** rtl/ssp_if.sv ***
`timescale 1ns/1ps
interface ssp_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    modport host (output sclk, output sdata, output load_strobe);
    modport device (input sclk, input sdata, input load_strobe);
endinterface

// *** rtl/ssp_device.sv ***
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_device
    import ssp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    ssp_if.device            link,
    input  wire logic        ref_tick_in,
    input  wire logic        vco_fast_in,
    input  wire logic        dig_lock_in,
    input  wire logic        ana_lock_in,
    input  wire logic        rf_fb_scaled_in,
    input  wire logic        ref_scaled_in,
    output logic             monitor_output_pin_out,
    output logic [15:0]      int_value_out,
    output logic             prescaler_out,
    output logic [23:0]      main_fraction_numerator_out,
    output logic [27:0]      aux_fraction_numerator_out,
    output logic [27:0]      aux_modulus_out,
    output logic [9:0]       ref_div_out,
    output logic             ref_doubler_out,
    output logic             reference_halve_out,
    output logic [3:0]       cp_current_out,
    output logic             phase_detector_pos_out,
    output logic [2:0]       out_div_out,
    output logic             fb_from_div_out,
    output logic [1:0]       out_power_out,
    output logic             rf_a_on_out,
    output logic             rf_b_on_out,
    output logic             cal_busy_out,
    output logic [1:0]       vco_core_out,
    output logic [7:0]       vco_band_out
);

    // ---------------------------------------------------------------
    // link domain shift register
    // ---------------------------------------------------------------
    ssp_word_t shift_q;

    always_ff @(posedge link.sclk)
    begin
        shift_q <= {shift_q[30:0], link.sdata};
    end

    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic [6:0] async_w;
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic       le_d1_q;
    logic       tick_d1_q;
    logic       le_rise_w;
    logic       tick_rise_w;

    // bit 6 strobe, 5 tick, 4 too fast, 3 dig lock, 2 ana lock,
    // 1 rf feedback, 0 reference
    assign async_w = {link.load_strobe, ref_tick_in, vco_fast_in,
                      dig_lock_in, ana_lock_in, rf_fb_scaled_in,
                      ref_scaled_in};

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sync1_q   <= 7'h00;
            sync2_q   <= 7'h00;
            le_d1_q   <= 1'b0;
            tick_d1_q <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1_q   <= async_w;
            sync2_q   <= sync1_q;
            le_d1_q   <= sync2_q[6];
            tick_d1_q <= sync2_q[5];
        end
    end

    assign le_rise_w   = sync2_q[6] & ~le_d1_q;
    assign tick_rise_w = sync2_q[5] & ~tick_d1_q;

    // ---------------------------------------------------------------
    // configuration latches
    // ---------------------------------------------------------------
    // shift word is stable while the strobe is high, so it is safe
    // to sample once the synchronised strobe edge is seen
    ssp_word_t latch_q [`SSP_NUM_REGS];
    logic      r0_wr_q;
    logic [3:0] sel_w;

    assign sel_w = shift_q[3:0];

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < `SSP_NUM_REGS; i++)
            begin
                latch_q[i] <= 32'h0000_0000;
            end
            r0_wr_q <= 1'b0;
        end
        else if (ce_in)
        begin
            r0_wr_q <= le_rise_w && (sel_w == 4'h0);
            if (le_rise_w && sel_w <= `SSP_LAST_REG)
            begin
                latch_q[sel_w] <= shift_q;
            end
        end
    end

    assign int_value_out = latch_q[0][`SSP_INT_LSB +: 16];
    assign prescaler_out = latch_q[0][`SSP_PRESCALER_BIT];
    assign phase_detector_pos_out = latch_q[4][`SSP_POL_BIT];
    assign fb_from_div_out = latch_q[6][`SSP_FB_SRC_BIT];
    assign out_power_out = latch_q[6][`SSP_PWR_LSB +: 2];

    // ---------------------------------------------------------------
    // double-buffered settings
    // ---------------------------------------------------------------
    logic [23:0] main_fraction_numerator_q;
    logic [27:0] aux_fraction_numerator_q;
    logic [27:0] aux_modulus_q;
    logic [9:0]  rdiv_q;
    logic [3:0]  cp_q;
    logic        doubler_q;
    logic        halve_q;
    logic [2:0]  odiv_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            main_fraction_numerator_q   <= 24'h00_0000;
            aux_fraction_numerator_q   <= 28'h000_0000;
            aux_modulus_q    <= 28'h000_0000;
            rdiv_q    <= 10'h000;
            cp_q      <= 4'h0;
            doubler_q <= 1'b0;
            halve_q   <= 1'b0;
        end
        else if (ce_in && r0_wr_q)
        begin
            main_fraction_numerator_q   <= latch_q[1][`SSP_MAIN_FRACTION_NUMERATOR_LSB +: 24];
            aux_fraction_numerator_q   <= {latch_q[13][`SSP_AUX_FRACTION_NUMERATOR_LSB +: 14],
                          latch_q[2][`SSP_AUX_FRACTION_NUMERATOR_LSB +: 14]};
            aux_modulus_q    <= {latch_q[13][`SSP_AUX_MODULUS_LSB +: 14],
                          latch_q[2][`SSP_AUX_MODULUS_LSB +: 14]};
            rdiv_q    <= latch_q[4][`SSP_RDIV_LSB +: 10];
            cp_q      <= latch_q[4][`SSP_CP_LSB +: 4];
            doubler_q <= latch_q[4][`SSP_DOUBLER_BIT];
            halve_q   <= latch_q[4][`SSP_HALVE_BIT];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            odiv_q <= 3'h0;
        end
        else if (ce_in && (r0_wr_q ||
                 !latch_q[4][`SSP_DIV_DBUF_BIT]))
        begin
            odiv_q <= latch_q[6][`SSP_ODIV_LSB +: 3];
        end
    end

    assign main_fraction_numerator_out = main_fraction_numerator_q;
    assign aux_fraction_numerator_out  = aux_fraction_numerator_q;
    assign aux_modulus_out             = aux_modulus_q;
    assign ref_div_out                 = rdiv_q;
    assign cp_current_out              = cp_q;
    assign ref_doubler_out             = doubler_q;
    assign reference_halve_out         = halve_q;
    assign out_div_out                 = odiv_q;

    // ---------------------------------------------------------------
    // output stages and monitor pin
    // ---------------------------------------------------------------
    logic rfa_q;
    logic rfb_q;
    logic mon_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rfa_q <= 1'b0;
            rfb_q <= 1'b0;
            mon_q <= 1'b0;
        end
        else if (ce_in)
        begin
            rfa_q <= latch_q[6][`SSP_RFA_EN_BIT] &&
                     (!latch_q[6][`SSP_MUTE_BIT] || sync2_q[3]);
            rfb_q <= latch_q[6][`SSP_RFB_EN_BIT];
            case (latch_q[4][`SSP_MON_LSB +: 3])
                `SSP_MON_DLOCK: mon_q <= sync2_q[3];
                `SSP_MON_ALOCK: mon_q <= sync2_q[2];
                `SSP_MON_RFFB:  mon_q <= sync2_q[1];
                `SSP_MON_REF:   mon_q <= sync2_q[0];
                default:        mon_q <= 1'b0;
            endcase
        end
    end

    assign rf_a_on_out           = rfa_q;
    assign rf_b_on_out           = rfb_q;
    assign monitor_output_pin_out = mon_q;

    // ---------------------------------------------------------------
    // core and band search
    // ---------------------------------------------------------------
    // successive approximation over 2 core bits and 8 band bits,
    // one step per reference counter tick
    ssp_cal_st_t cal_q;
    logic [9:0]  code_q;
    logic [3:0]  idx_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cal_q  <= SSP_C_IDLE;
            code_q <= 10'h000;
            idx_q  <= 4'h0;
        end
        else if (ce_in)
        begin
            case (cal_q)
                SSP_C_IDLE:
                begin
                    if (r0_wr_q && latch_q[0][`SSP_AUTOCAL_BIT])
                    begin
                        cal_q  <= SSP_C_RUN;
                        code_q <= 10'h200;
                        idx_q  <= 4'h9;
                    end
                end
                SSP_C_RUN:
                begin
                    if (tick_rise_w)
                    begin
                        if (idx_q == 4'h0)
                        begin
                            code_q[0] <= ~sync2_q[4];
                            cal_q     <= SSP_C_IDLE;
                        end
                        else
                        begin
                            if (sync2_q[4])
                            begin
                                code_q[idx_q] <= 1'b0;
                            end
                            code_q[idx_q - 4'h1] <= 1'b1;
                            idx_q <= idx_q - 4'h1;
                        end
                    end
                end
                default: cal_q <= SSP_C_IDLE;
            endcase
        end
    end

    assign cal_busy_out = cal_q[1];
    assign vco_core_out = code_q[9:8];
    assign vco_band_out = code_q[7:0];

endmodule

// *** rtl/ssp_host.sv ***
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_host
    import ssp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    ssp_if.host              link
);

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    ssp_host_st_t st_q;
    ssp_word_t    last_q;
    logic [7:0]   half_q;
    logic [31:0]  rdata_q;
    logic         ready_q;
    logic         err_q;
    logic         acc_w;
    logic         start_w;
    logic         busy_w;

    assign busy_w  = (st_q != SSP_H_IDLE);
    assign acc_w   = psel_in && penable_in && ready_q;
    assign start_w = acc_w && pwrite_in && !busy_w &&
                     (paddr_in == `SSP_ADDR_TXDATA);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            half_q  <= `SSP_HALFDIV_RST;
        end
        else if (ce_in)
        begin
            ready_q <= psel_in && !penable_in;
            if (psel_in && !penable_in)
            begin
                err_q   <= 1'b0;
                rdata_q <= 32'h0000_0000;
                case (paddr_in)
                    `SSP_ADDR_TXDATA:  rdata_q <= last_q;
                    `SSP_ADDR_STATUS:  rdata_q <= {31'h0, busy_w};
                    `SSP_ADDR_HALFDIV: rdata_q <= {24'h0, half_q};
                    default:           err_q   <= 1'b1;
                endcase
                if (pwrite_in && busy_w &&
                    paddr_in == `SSP_ADDR_TXDATA)
                begin
                    err_q <= 1'b1;
                end
            end
            if (acc_w && pwrite_in && paddr_in == `SSP_ADDR_HALFDIV &&
                pwdata_in[7:0] != 8'h00)
            begin
                half_q <= pwdata_in[7:0];
            end
        end
    end

    assign pready_out  = ready_q;
    assign pslverr_out = err_q;
    assign prdata_out  = rdata_q;

    // ---------------------------------------------------------------
    // serial sender
    // ---------------------------------------------------------------
    ssp_word_t  tx_q;
    logic [4:0] bit_q;
    logic [7:0] cnt_q;
    logic       sclk_q;
    logic       sdata_q;
    logic       le_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q    <= SSP_H_IDLE;
            last_q  <= 32'h0000_0000;
            tx_q    <= 32'h0000_0000;
            bit_q   <= 5'h00;
            cnt_q   <= 8'h00;
            sclk_q  <= 1'b0;
            sdata_q <= 1'b0;
            le_q    <= 1'b0;
        end
        else if (ce_in)
        begin
            case (st_q)
                SSP_H_IDLE:
                begin
                    if (start_w)
                    begin
                        last_q  <= pwdata_in;
                        tx_q    <= pwdata_in;
                        sdata_q <= pwdata_in[31];
                        bit_q   <= 5'h00;
                        cnt_q   <= half_q - 8'h01;
                        st_q    <= SSP_H_SHIFT;
                    end
                end
                SSP_H_SHIFT:
                begin
                    if (cnt_q != 8'h00)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    else
                    begin
                        cnt_q  <= half_q - 8'h01;
                        sclk_q <= ~sclk_q;
                        if (sclk_q && bit_q == 5'h1f)
                        begin
                            le_q  <= 1'b1;
                            cnt_q <= `SSP_LE_HOLD_CYC - 8'h01;
                            st_q  <= SSP_H_LOAD;
                        end
                        else if (sclk_q)
                        begin
                            tx_q    <= {tx_q[30:0], 1'b0};
                            sdata_q <= tx_q[30];
                            bit_q   <= bit_q + 5'h01;
                        end
                    end
                end
                SSP_H_LOAD:
                begin
                    if (cnt_q != 8'h00)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    else
                    begin
                        le_q <= 1'b0;
                        st_q <= SSP_H_IDLE;
                    end
                end
                default: st_q <= SSP_H_IDLE;
            endcase
        end
    end

    assign link.sclk        = sclk_q;
    assign link.sdata       = sdata_q;
    assign link.load_strobe = le_q;

endmodule

// *** dv/ssp_link_assertions.sv ***
`timescale 1ns/1ps
module ssp_link_assertions
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic sclk,
    input  wire logic sdata,
    input  wire logic load_strobe
);
    // ----------------------------------------
    // rising serial clocks since last strobe
    // ----------------------------------------
    logic [5:0] bit_cnt_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || load_strobe)
            bit_cnt_q <= 6'h00;
        else if ($rose(sclk))
            bit_cnt_q <= bit_cnt_q + 6'h01;
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------
    // link framing
    // ----------------------------------------
    a_reset_idle: assert property
        ($rose(rst_n_in) |-> !sclk && !load_strobe)
        else $error("link not idle after reset");
    a_data_stable: assert property (sclk |-> $stable(sdata))
        else $error("data moved while serial clock high");
    a_sclk_half: assert property
        ($rose(sclk) |-> sclk[*2] ##1 !sclk)
        else $error("serial clock high time wrong");
    a_next_bit: assert property
        ($fell(sclk) && bit_cnt_q != 6'h20 |-> ##2 $rose(sclk))
        else $error("next serial clock late");
    a_bit_count: assert property
        ($rose(load_strobe) |-> bit_cnt_q == 6'h20)
        else $error("strobe without 32 bits");
    a_strobe_follows: assert property
        ($fell(sclk) && bit_cnt_q == 6'h20 |-> ##[0:4] $rose(load_strobe))
        else $error("no strobe after last bit");
    a_strobe_width: assert property
        ($rose(load_strobe) |-> load_strobe[*4] ##1 !load_strobe)
        else $error("strobe width wrong");
    a_sclk_quiet: assert property (load_strobe |-> !sclk)
        else $error("serial clock moved during strobe");

    c_word: cover property ($rose(load_strobe));
    c_full: cover property (bit_cnt_q == 6'h20);
    c_back: cover property ($fell(load_strobe) ##[1:40] $rose(sclk));
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        clk_in, rst_n_in, psel, penable, pwrite, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, tick, fast, dlock, alock, rffb, refs;
    logic        mon, pres, dbl, halve, pol, fbdiv, rfa, rfb, busy;
    logic [15:0] iv;
    logic [23:0] main_fraction_numerator;
    logic [27:0] aux_fraction_numerator, aux_modulus;
    logic [9:0]  rdiv;
    logic [3:0]  cp;
    logic [2:0]  odiv;
    logic [1:0]  pwr, core;
    logic [7:0]  band;
    int          n_fail, compares;
    ssp_if       lnk ();

    ssp_host i_ssp_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .link(lnk));
    ssp_device i_ssp_device (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce), .link(lnk), .ref_tick_in(tick), .vco_fast_in(fast),
        .dig_lock_in(dlock), .ana_lock_in(alock), .rf_fb_scaled_in(rffb),
        .ref_scaled_in(refs), .monitor_output_pin_out(mon),
        .int_value_out(iv), .prescaler_out(pres),
        .main_fraction_numerator_out(main_fraction_numerator),
        .aux_fraction_numerator_out(aux_fraction_numerator), .aux_modulus_out(aux_modulus),
        .ref_div_out(rdiv), .ref_doubler_out(dbl),
        .reference_halve_out(halve), .cp_current_out(cp),
        .phase_detector_pos_out(pol), .out_div_out(odiv),
        .fb_from_div_out(fbdiv), .out_power_out(pwr), .rf_a_on_out(rfa),
        .rf_b_on_out(rfb), .cal_busy_out(busy), .vco_core_out(core),
        .vco_band_out(band));
    ssp_link_assertions i_ssp_link_assertions (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .sclk(lnk.sclk), .sdata(lnk.sdata),
        .load_strobe(lnk.load_strobe));

    // ----------------------------------------
    // word builders
    // ----------------------------------------
    function automatic logic [31:0] r0(logic ac, logic pr, logic [15:0] v);
        return {10'h0, ac, pr, v, 4'h0};
    endfunction
    function automatic logic [31:0] r4(logic [2:0] m, logic db);
        return {2'h0, m, 2'h3, 10'h2a5, db, 4'h9, 2'h0, 1'b1, 3'h0, 4'h4};
    endfunction
    function automatic logic [31:0] r6(logic [2:0] d, logic mu, logic b,
                                       logic a);
        return {7'h0, 1'b1, d, 9'h0, mu, b, 3'h0, a, 2'h0, 4'h6};
    endfunction

    // ----------------------------------------
    // bench services
    // ----------------------------------------
    task automatic close_out();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            $display("Error at %0t: %s", $time, m);
            n_fail++;
        end
    endtask
    task automatic hang(input string m);
        $display("Error at %0t: timeout %s", $time, m);
        n_fail++;
        close_out();
    endtask
    // one idle edge first, so psel never drops and rises in one step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hang("apb");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // margin covers the strobe synchroniser and the buffered update
    task automatic wait_idle();
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do
        begin
            apb(1'b0, 8'h04, 32'h0, r, e);
            n++;
        end
        while (r[0] !== 1'b0 && n < 200);
        if (r[0] !== 1'b0)
            hang("link");
        repeat (6) @(posedge clk_in);
    endtask
    task automatic send(input logic [31:0] w);
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'h00, w, r, e);
        wait_idle();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_apb();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk(r === 32'h2 && e === 1'b0, "half divider reset value");
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk(r === 32'h0 && e === 1'b1, "unmapped read");
        apb(1'b1, 8'h08, 32'h0, r, e);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk(r === 32'h2, "half divider took zero");
        apb(1'b1, 8'h00, r0(1'b0, 1'b0, 16'h0055), r, e);
        apb(1'b1, 8'h00, 32'h11, r, e);
        chk(e === 1'b1, "write while busy accepted");
        wait_idle();
        apb(1'b0, 8'h00, 32'h0, r, e);
        chk(r === r0(1'b0, 1'b0, 16'h0055), "last word readback");
        chk(iv === 16'h0055, "first word not latched");
        $display("t_apb done");
    endtask
    task automatic t_route();
        send(r0(1'b0, 1'b1, 16'h1234));
        chk(iv === 16'h1234 && pres === 1'b1, "word order");
        for (int c = 14; c < 16; c++)
        begin
            send({28'hfffffff, c[3:0]});
            chk(iv === 16'h1234 && odiv === 3'h0, "free code hit");
        end
        $display("t_route done");
    endtask
    task automatic t_dbuf();
        send({4'h0, 24'habcdef, 4'h1});
        send({14'h1555, 14'h2aaa, 4'h2});
        send({14'h0f0f, 14'h3003, 4'hd});
        send(r4(3'h0, 1'b0));
        chk(main_fraction_numerator === 24'h0 && aux_modulus === 28'h0, "early fraction");
        chk(rdiv === 10'h0 && aux_fraction_numerator === 28'h0, "early divider");
        chk(cp === 4'h0 && dbl === 1'b0 && halve === 1'b0, "early ref");
        chk(pol === 1'b1, "polarity bit");
        send(r0(1'b0, 1'b1, 16'h1234));
        chk(main_fraction_numerator === 24'habcdef, "main fraction");
        chk(aux_fraction_numerator === {14'h0f0f, 14'h1555}, "aux fraction");
        chk(aux_modulus === {14'h3003, 14'h2aaa}, "aux modulus");
        chk(rdiv === 10'h2a5 && cp === 4'h9, "ref divider");
        chk(dbl === 1'b1 && halve === 1'b1, "ref doubler");
        $display("t_dbuf done");
    endtask
    task automatic t_div();
        send(r6(3'h5, 1'b0, 1'b0, 1'b1));
        chk(odiv === 3'h5 && fbdiv === 1'b1, "divider now");
        chk(pwr === 2'h3, "power field");
        send(r4(3'h0, 1'b1));
        send(r6(3'h2, 1'b0, 1'b0, 1'b1));
        chk(odiv === 3'h5, "divider not held");
        send(r0(1'b0, 1'b1, 16'h1234));
        chk(odiv === 3'h2, "divider not applied");
        $display("t_div done");
    endtask
    task automatic t_mute();
        dlock <= 1'b0;
        send(r6(3'h2, 1'b1, 1'b1, 1'b1));
        chk(rfa === 1'b0 && rfb === 1'b1, "mute before lock");
        ce    <= 1'b0;
        dlock <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk(rfa === 1'b0, "output moved while frozen");
        ce <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk(rfa === 1'b1, "output after lock");
        send(r6(3'h2, 1'b0, 1'b1, 1'b0));
        chk(rfa === 1'b0 && rfb === 1'b1, "second output alone");
        $display("t_mute done");
    endtask
    task automatic t_mon();
        logic e;
        for (int c = 0; c < 5; c++)
        begin
            send(r4(c[2:0], 1'b1));
            for (int v = 0; v < 4; v++)
            begin
                dlock <= v[0];
                alock <= v[1];
                rffb  <= !v[0];
                refs  <= !v[1];
                repeat (6) @(posedge clk_in);
                e = (c == 1) ? v[0] : (c == 2) ? v[1] :
                    (c == 3) ? !v[0] : (c == 4) ? !v[1] : 1'b0;
                chk(mon === e, "monitor source");
            end
        end
        $display("t_mon done");
    endtask
    task automatic t_cal(input logic f, input logic [9:0] want);
        fast <= f;
        send(r0(1'b1, 1'b1, 16'h1234));
        repeat (20) @(posedge clk_in);
        chk(busy === 1'b1, "search ran without ticks");
        repeat (10)
        begin
            tick <= 1'b1;
            repeat (4) @(posedge clk_in);
            tick <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
        repeat (6) @(posedge clk_in);
        chk(busy === 1'b0 && {core, band} === want, "search end");
        $display("t_cal done");
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    initial
    begin
        {rst_n_in, psel, penable, pwrite, tick, fast} = 6'h0;
        {dlock, alock, rffb, refs} = 4'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        compares = 0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_apb();
        t_route();
        t_dbuf();
        t_div();
        t_mute();
        t_mon();
        t_cal(1'b0, 10'h3ff);
        t_cal(1'b1, 10'h000);
        close_out();
    end
endmodule
